// file: logic/eetw_pkg.sv
// Purpose: Shared constants and types for the two-wire EEPROM slave front end
// Assumes: Core clock of 250 MHz; bus pins idle high
// Notes: Field positions refer to the device address and word address bytes

package eetw_pkg;

  // Core clock rate in MHz
  localparam int CLK_MHZ = 250;
  // Longest spike the pin filter must drop, in ns
  localparam int FILT_NS = 50;
  // Filter length in cycles, rounded up
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;

  // Type identifiers in the device address byte
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_IDENT = 4'hB;

  // Device address byte field positions
  localparam int DEV_TYPE_HI = 7;
  localparam int DEV_TYPE_LO = 4;
  localparam int DEV_CS_HIGH = 3;
  localparam int DEV_CS_LOW = 2;
  localparam int DEV_ADDR_MSB = 1;
  localparam int DEV_RW = 0;

  // Word address selector field and its codes
  localparam int WORD_SEL_HI = 7;
  localparam int WORD_SEL_LO = 6;
  localparam logic [1:0] SEL_IDENTIFICATION_PAGE = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_UNIQUE_ID = 2'h2;
  localparam logic [1:0] SEL_SOFT_PROTECT = 2'h3;

  // Data byte bits that carry the lock and soft-protect values
  localparam int LOCK_DATA_BIT = 1;
  localparam int SWP_DATA_BIT = 0;

  // Bits per byte before the acknowledge clock
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Reset levels of the filtered pins
  localparam logic [1:0] BUS_IDLE = 2'h3;
  localparam logic [3:0] PINS_RST = 4'h0;

  // What a command addresses
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_ARRAY,
    TGT_IDENTIFICATION_PAGE,
    TGT_LOCK,
    TGT_SOFT_PROTECT,
    TGT_UNIQUE_ID
  } eetw_target_t;

  // Decoded write command
  typedef struct packed {
    eetw_target_t target;
    logic [8:0] array_address;
    logic [7:0] word_address;
  } eetw_cmd_t;

  // Filtered bus levels
  typedef struct packed {
    logic scl;
    logic sda;
  } eetw_bus_t;

  // Filtered slow pins
  typedef struct packed {
    logic chip_select_pin_high;
    logic chip_select_pin_low;
    logic write_protect;
    logic por_reset;
  } eetw_pins_t;

endpackage : eetw_pkg

// file: logic/eetw_pin_filter.sv
// Purpose: Two-flop synchroniser and glitch filter for slow or noisy pins
// Assumes: Pins are asynchronous to clk_in
// Notes: A level passes only after holding FILT_CYC cycles

`timescale 1ns/1ps
`default_nettype none

module eetw_pin_filter
  import eetw_pkg::*;
#(
  parameter int W = 2,
  parameter int FILT_CYC = 13,
  parameter logic [W-1:0] RST_LVL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  localparam int CW = $clog2(FILT_CYC + 1);

  // All state of the filter
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] lvl;
    logic [W-1:0][CW-1:0] cnt;
  } eetw_filt_t;

  eetw_filt_t filt_q;
  eetw_filt_t filt_d;

  // First flop feeds only the second; filter looks at the second
  always_comb begin
    filt_d = filt_q;
    filt_d.s1 = pin_in;
    filt_d.s2 = filt_q.s1;
    for (int i = 0; i < W; i++) begin
      if (filt_q.s2[i] != filt_q.lvl[i]) begin
        // Spike shorter than the window is dropped
        if (filt_q.cnt[i] == CW'(FILT_CYC - 1)) begin
          filt_d.lvl[i] = filt_q.s2[i];
          filt_d.cnt[i] = '0;
        end else begin
          filt_d.cnt[i] = filt_q.cnt[i] + CW'(1);
        end
      end else begin
        filt_d.cnt[i] = '0;
      end
    end
  end

  // Register the state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      filt_q <= '{s1: RST_LVL, s2: RST_LVL, lvl: RST_LVL, cnt: '0};
    end else begin
      filt_q <= filt_d;
    end
  end

  assign level_out = filt_q.lvl;

endmodule : eetw_pin_filter

`default_nettype wire

// file: logic/eetw_link_sampler.sv
// Purpose: Samples SDA on each rising SCL edge in the link clock domain
// Assumes: SCL clock may stop between frames
// Notes: Toggle marks a new bit; bit is stable until the next rise

`timescale 1ns/1ps
`default_nettype none

module eetw_link_sampler
  import eetw_pkg::*;
(
  input wire logic scl_clk_in,
  input wire logic rst_in,
  input wire logic sda_in,
  output logic bit_out,
  output logic toggle_out
);

  // All state of the sampler
  typedef struct packed {
    logic bit_val;
    logic toggle;
  } eetw_link_t;

  eetw_link_t link_q;
  eetw_link_t link_d;

  // Capture bit and flip the event toggle
  always_comb begin
    link_d = link_q;
    link_d.bit_val = sda_in;
    link_d.toggle = ~link_q.toggle;
  end

  // Register on the rising SCL edge
  always_ff @(posedge scl_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  assign bit_out = link_q.bit_val;
  assign toggle_out = link_q.toggle;

endmodule : eetw_link_sampler

`default_nettype wire

// file: logic/eetw_slave_front.sv
// Purpose: Two-wire serial slave front end of a small serial EEPROM
// Assumes: scl_clk_in and scl_in are the same SCL pin; SDA is open drain
// Notes: Data write, write timing and read data paths sit outside this block

`timescale 1ns/1ps
`default_nettype none

module eetw_slave_front
  import eetw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic chip_select_pin_low_in,
  input wire logic chip_select_pin_high_in,
  input wire logic write_protect_in,
  input wire logic por_reset_in,
  input wire logic soft_protect_bit_in,
  input wire logic identification_page_locked_in,
  input wire logic write_busy_in,
  output eetw_cmd_t cmd_out,
  output logic cmd_valid_out,
  output logic [7:0] data_out,
  output logic data_valid_out,
  output logic write_launch_out,
  output logic write_blocked_out,
  output logic standby_out
);

  // Transaction phases
  typedef enum {
    ST_IDLE,
    ST_DEV,
    ST_WORD,
    ST_DATA,
    ST_PASSIVE
  } eetw_state_t;

  // All state of the front end
  typedef struct packed {
    eetw_state_t state;
    logic [2:0] tog;         // Toggle sync chain plus previous
    logic scl_p;             // Filtered SCL one cycle ago
    logic sda_p;             // Filtered SDA one cycle ago
    logic [7:0] shift;       // Incoming byte
    logic [3:0] cnt;         // Bits received in this byte
    logic ack_phase;         // In the ninth clock
    logic ack_drive;         // Pulling SDA low
    logic dev_read;          // Direction of this command
    logic [3:0] dev_type;    // Type identifier seen
    logic dev_msb;           // Array address MSB seen
    logic [4:0] data_cnt;    // Data bytes acknowledged
    logic data_acked;        // Last data byte acknowledged
    eetw_cmd_t cmd;          // Command output
    logic cmd_valid;
    logic [7:0] data;
    logic data_valid;
    logic launch;
    logic blocked;
    logic standby;
  } eetw_core_t;

  eetw_core_t core_q;
  eetw_core_t core_d;

  eetw_bus_t bus_f;   // Filtered bus levels
  eetw_pins_t pins_f; // Filtered slow pins
  logic link_bit;     // Bit sampled in SCL domain
  logic link_toggle;  // Bit event toggle from SCL domain

  // Bus pins: sync plus glitch filter before start, stop and fall detection
  eetw_pin_filter #(
    .W(2),
    .FILT_CYC(FILT_CYC),
    .RST_LVL(BUS_IDLE)
  ) u_bus_filter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in({scl_in, sda_in}),
    .level_out(bus_f)
  );

  // Strap and control pins share the same filter
  eetw_pin_filter #(
    .W(4),
    .FILT_CYC(FILT_CYC),
    .RST_LVL(PINS_RST)
  ) u_pin_filter (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in({chip_select_pin_high_in, chip_select_pin_low_in, write_protect_in, por_reset_in}),
    .level_out(pins_f)
  );

  // Bit capture on the link clock itself
  eetw_link_sampler u_link (
    .scl_clk_in(scl_clk_in),
    .rst_in(rst_in),
    .sda_in(sda_in),
    .bit_out(link_bit),
    .toggle_out(link_toggle)
  );

  // Which special function or array the command targets
  function automatic eetw_target_t decode_target(
    input logic [3:0] dev_type,
    input logic [7:0] word
  );
    eetw_target_t t;
    t = TGT_NONE;
    if (dev_type == TYPE_ARRAY) begin
      t = TGT_ARRAY;
    end else begin
      // Selector bits pick the function
      case (word[WORD_SEL_HI:WORD_SEL_LO])
        SEL_IDENTIFICATION_PAGE: t = TGT_IDENTIFICATION_PAGE;
        SEL_LOCK: t = TGT_LOCK;
        SEL_UNIQUE_ID: t = TGT_UNIQUE_ID;
        SEL_SOFT_PROTECT: t = TGT_SOFT_PROTECT;
        default: t = TGT_NONE;
      endcase
    end
    return t;
  endfunction : decode_target

  // Whether a data byte of a write must be refused
  function automatic logic refuse_data(
    input eetw_cmd_t cmd,
    input logic [7:0] data,
    input logic wp,
    input logic soft_protect_bit,
    input logic locked
  );
    logic r;
    r = wp;
    case (cmd.target)
      TGT_ARRAY: r = r | soft_protect_bit;
      TGT_IDENTIFICATION_PAGE: r = r | soft_protect_bit | locked;
      // Relocking or a lock byte without its flag is refused
      TGT_LOCK: r = r | locked | ~data[LOCK_DATA_BIT];
      TGT_SOFT_PROTECT: r = r;
      // Unique ID is read only
      TGT_UNIQUE_ID: r = 1'b1;
      default: r = 1'b1;
    endcase
    return r;
  endfunction : refuse_data

  // Next-state logic of the whole front end
  always_comb begin
    logic start_ev;
    logic stop_ev;
    logic rise_ev;
    logic fall_ev;
    logic match;
    logic ok;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    match = 1'b0;
    ok = 1'b0;
    core_d = core_q;
    core_d.cmd_valid = 1'b0;
    core_d.data_valid = 1'b0;
    core_d.launch = 1'b0;

    // Toggle crossing; first flop only feeds the second
    core_d.tog = {core_q.tog[1], core_q.tog[0], link_toggle};
    core_d.scl_p = bus_f.scl;
    core_d.sda_p = bus_f.sda;

    // SDA edges with SCL high are start or stop
    start_ev = bus_f.scl & core_q.scl_p & core_q.sda_p & ~bus_f.sda;
    stop_ev = bus_f.scl & core_q.scl_p & ~core_q.sda_p & bus_f.sda;
    // Bit event from the link domain, read only behind the second flop
    rise_ev = core_q.tog[2] ^ core_q.tog[1];
    // Fall seen on filtered SCL, so it lags the raw pin by the filter
    fall_ev = core_q.scl_p & ~bus_f.scl;

    // Protect pin or soft-protect bit blocks array writes
    core_d.blocked = pins_f.write_protect | soft_protect_bit_in;

    if (pins_f.por_reset) begin
      // Held idle while power reset stands; standby unless a write is busy
      // Command and data registers keep their last value meanwhile
      core_d.state = ST_IDLE;
      core_d.ack_drive = 1'b0;
      core_d.ack_phase = 1'b0;
    end else if (start_ev) begin
      // Start, also repeated start, opens a new command
      core_d.state = ST_DEV;
      core_d.cnt = '0;
      core_d.ack_phase = 1'b0;
      core_d.ack_drive = 1'b0;
      core_d.data_cnt = '0;
      core_d.data_acked = 1'b0;
    end else if (stop_ev) begin
      // Launch only right after an acknowledged data byte
      // The Stop clock's own SCL rise has shifted exactly one bit by now;
      // a Stop after any further bits leaves the write unlaunched
      ok = (core_q.cmd.target == TGT_ARRAY) | (core_q.cmd.target == TGT_IDENTIFICATION_PAGE)
           | (core_q.data_cnt == 5'h01);
      if ((core_q.state == ST_DATA) && !core_q.ack_phase && (core_q.cnt == 4'h1)
          && core_q.data_acked && ok) begin
        core_d.launch = 1'b1;
      end
      core_d.state = ST_IDLE;
      core_d.ack_drive = 1'b0;
      core_d.ack_phase = 1'b0;
    end else begin
      case (core_q.state)
        // Standby and passive read ignore bits until start
        ST_IDLE: core_d.ack_drive = 1'b0;
        // Read data path lives outside, so stay off the bus
        ST_PASSIVE: core_d.ack_drive = 1'b0;
        ST_DEV, ST_WORD, ST_DATA: begin
          if (!core_q.ack_phase) begin
            // Shift MSB first, one bit per SCL rise
            if (rise_ev && (core_q.cnt < BITS_PER_BYTE)) begin
              core_d.shift = {core_q.shift[6:0], link_bit};
              core_d.cnt = core_q.cnt + 4'h1;
            end
            // Eighth bit done: ack goes out on the SCL fall
            if (fall_ev && (core_q.cnt == BITS_PER_BYTE)) begin
              core_d.ack_phase = 1'b1;
              case (core_q.state)
                ST_DEV: begin
                  // Type, selects, msb and direction
                  match = ((core_q.shift[DEV_TYPE_HI:DEV_TYPE_LO] == TYPE_ARRAY)
                           | (core_q.shift[DEV_TYPE_HI:DEV_TYPE_LO] == TYPE_IDENT))
                          & (core_q.shift[DEV_CS_HIGH] == pins_f.chip_select_pin_high)
                          & (core_q.shift[DEV_CS_LOW] == pins_f.chip_select_pin_low)
                          & ~write_busy_in;
                  core_d.ack_drive = match;
                  core_d.dev_type = core_q.shift[DEV_TYPE_HI:DEV_TYPE_LO];
                  core_d.dev_msb = core_q.shift[DEV_ADDR_MSB];
                  core_d.dev_read = core_q.shift[DEV_RW];
                end
                ST_WORD: begin
                  // Word address always acknowledged
                  core_d.ack_drive = 1'b1;
                  core_d.cmd.target = decode_target(core_q.dev_type, core_q.shift);
                  core_d.cmd.array_address = {core_q.dev_msb, core_q.shift};
                  core_d.cmd.word_address = core_q.shift;
                  core_d.cmd_valid = 1'b1;
                end
                default: begin
                  // Data byte of a write
                  ok = ~refuse_data(core_q.cmd, core_q.shift, pins_f.write_protect,
                                    soft_protect_bit_in, identification_page_locked_in);
                  core_d.ack_drive = ok;
                  core_d.data_acked = ok;
                  if (ok) begin
                    core_d.data = core_q.shift;
                    core_d.data_valid = 1'b1;
                    if (core_q.data_cnt != 5'h1F) begin
                      core_d.data_cnt = core_q.data_cnt + 5'h01;
                    end
                  end
                end
              endcase
            end
          end else if (fall_ev) begin
            // Ninth clock over: release SDA on its fall
            core_d.ack_phase = 1'b0;
            core_d.ack_drive = 1'b0;
            core_d.cnt = '0;
            case (core_q.state)
              ST_DEV: begin
                if (!core_q.ack_drive) begin
                  core_d.state = ST_IDLE;
                end else if (core_q.dev_read) begin
                  core_d.state = ST_PASSIVE;
                end else begin
                  core_d.state = ST_WORD;
                end
              end
              default: core_d.state = ST_DATA;
            endcase
          end
        end
        default: core_d.state = ST_IDLE;
      endcase
    end

    // Standby when idle and no internal work runs
    core_d.standby = (core_d.state == ST_IDLE) & ~write_busy_in & ~core_d.launch;
  end

  // Register the state; reset lands in standby
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Previous bus levels idle high, so no false Start after reset
      core_q <= '{state: ST_IDLE, tog: '0, scl_p: 1'b1, sda_p: 1'b1, standby: 1'b1,
                  default: '0};
    end else begin
      core_q <= core_d;
    end
  end

  // Open drain: low level, enable active low while pulling
  assign sda_out = 1'b0;
  assign sda_oe_n_out = ~core_q.ack_drive;
  // Outputs come straight from the state register
  assign cmd_out = core_q.cmd;
  assign cmd_valid_out = core_q.cmd_valid;
  assign data_out = core_q.data;
  assign data_valid_out = core_q.data_valid;
  assign write_launch_out = core_q.launch;
  assign write_blocked_out = core_q.blocked;
  assign standby_out = core_q.standby;

endmodule : eetw_slave_front

`default_nettype wire

// file: verif/eetw_slave_front_monitor.sv
// Purpose: Concurrent checks on the two-wire slave front end ports
// Assumes: Bound into eetw_slave_front; all checks in the core clock domain
// Notes: Link-side bit order and ack levels are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module eetw_slave_front_monitor
  import eetw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic soft_protect_bit_in,
  input wire logic por_reset_in,
  input wire logic write_busy_in,
  input wire eetw_cmd_t cmd_out,
  input wire logic cmd_valid_out,
  input wire logic data_valid_out,
  input wire logic write_launch_out,
  input wire logic write_blocked_out,
  input wire logic standby_out
);
  // Cycles the power-on reset pin has stayed high, saturating
  logic [4:0] por_cnt_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Counter restarts whenever the pin drops, so a short glitch never counts
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) por_cnt_q <= 5'h00;
    else if (!por_reset_in) por_cnt_q <= 5'h00;
    else if (por_cnt_q != 5'h1F) por_cnt_q <= por_cnt_q + 5'h01;
  end
  AST_SDA_ZERO: assert property (sda_out == 1'b0) else $error("sda value not zero");
  AST_ACK_HOLD: assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*8])
    else $error("ack drive too short");
  AST_DRIVE_SCL_LOW: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("sda drive changed while scl high");
  AST_WORD_ACK: assert property (cmd_valid_out |-> ##[0:3] !sda_oe_n_out)
    else $error("word byte taken without ack");
  AST_CMD_TARGET: assert property (cmd_valid_out |-> cmd_out.target != TGT_NONE)
    else $error("command without target");
  AST_DATA_PULSE: assert property (data_valid_out |=> !data_valid_out)
    else $error("data strobe longer than one cycle");
  AST_LAUNCH: assert property (write_launch_out |-> !standby_out ##1 !write_launch_out)
    else $error("launch pulse malformed");
  AST_BLOCK_SWP: assert property ($rose(soft_protect_bit_in) |-> ##[1:2] write_blocked_out)
    else $error("soft protect not blocking");
  AST_POR_IDLE: assert property (por_cnt_q > 5'h14
    |-> sda_oe_n_out && !cmd_valid_out && !write_launch_out)
    else $error("activity during power-on reset");
  AST_BUSY_WAKE: assert property (write_busy_in [*3] |-> !standby_out)
    else $error("standby while busy");
endmodule : eetw_slave_front_monitor
bind eetw_slave_front eetw_slave_front_monitor u_eetw_slave_front_monitor (.clk_in(clk_in), .rst_in(rst_in),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .soft_protect_bit_in(soft_protect_bit_in),
  .por_reset_in(por_reset_in), .write_busy_in(write_busy_in), .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
  .data_valid_out(data_valid_out), .write_launch_out(write_launch_out),
  .write_blocked_out(write_blocked_out), .standby_out(standby_out));
`default_nettype wire

// file: verif/eetw_master_model.sv
// Purpose: Behavioural two-wire bus master driving SCL and SDA
// Assumes: SDA has a pull-up; a release reads back high
// Notes: SCL stands high between frames; half period 20 link cycles
`timescale 1ns/1ps
`default_nettype none
module eetw_master_model (
  input wire logic link_clk_in,
  input wire logic sda_wire_in,
  output logic scl_out,
  output logic sda_rel_out
);
  // Idle bus: both lines released high
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  // Move lines just after a link edge, then hold them
  task automatic set_lines(input logic c, input logic d, input int n);
    @(posedge link_clk_in);
    scl_out <= c;
    sda_rel_out <= d;
    repeat (n) @(posedge link_clk_in);
  endtask : set_lines
  // Start: SDA falls while SCL high; always issued before a command
  task automatic start();
    set_lines(1'b0, 1'b1, 20);
    set_lines(1'b1, 1'b1, 20);
    set_lines(1'b1, 1'b0, 20);
    set_lines(1'b0, 1'b0, 20);
  endtask : start
  // Stop: SDA rises while SCL high
  task automatic stop();
    set_lines(1'b0, 1'b0, 20);
    set_lines(1'b1, 1'b0, 20);
    set_lines(1'b1, 1'b1, 20);
  endtask : stop
  // SCL falls first, SDA moves only in the low phase, sampled at the rise
  task automatic clock_bit(input logic d, output logic s);
    set_lines(1'b0, sda_rel_out, 10);
    set_lines(1'b0, d, 10);
    @(posedge link_clk_in);
    scl_out <= 1'b1;
    s = sda_wire_in;
    repeat (20) @(posedge link_clk_in);
  endtask : clock_bit
  // Byte MSB first, then released ninth clock for the answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = !s;
    set_lines(1'b0, 1'b1, 10);
  endtask : send_byte
  // Bus recovery: Start, nine clocks, Start, Stop
  task automatic recover();
    logic s;
    start();
    repeat (9) clock_bit(1'b1, s);
    set_lines(1'b0, 1'b1, 10);
    start();
    stop();
  endtask : recover
endmodule : eetw_master_model
`default_nettype wire

// file: verif/eetw_slave_front_bench.sv
// Purpose: Self-checking bench for the two-wire slave front end
// Assumes: Master model drives the link; pins change only between frames
// Notes: Random commands from a fixed xorshift seed plus corner cases
`timescale 1ns/1ps
`default_nettype none
module eetw_slave_front_bench;
  import eetw_pkg::*;
  logic clk_in, rst_in, link_clk, scl, m_rel, sda_wire;
  logic csl, csh, wp, por, soft_protect_bit, lock, busy;
  logic sda_out, sda_oe_n_out, cmd_valid_out, data_valid_out, write_launch_out, write_blocked_out, standby_out;
  logic [7:0] data_out, cap_data, a_dev;
  eetw_cmd_t cmd_out, cap_cmd;
  int num_errors = 0, checks_done = 0, n_cmd = 0, n_data = 0, n_launch = 0;
  logic [31:0] rnd = 32'h0000D46C;
  // Open-drain wire with pull-up: low if either side pulls
  assign sda_wire = m_rel & (sda_oe_n_out | sda_out);
  eetw_master_model u_eetw_master_model (.link_clk_in(link_clk), .sda_wire_in(sda_wire), .scl_out(scl),
    .sda_rel_out(m_rel));
  eetw_slave_front u_eetw_slave_front (.clk_in(clk_in), .rst_in(rst_in), .scl_clk_in(scl), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .chip_select_pin_low_in(csl),
    .chip_select_pin_high_in(csh), .write_protect_in(wp), .por_reset_in(por), .soft_protect_bit_in(soft_protect_bit),
    .identification_page_locked_in(lock), .write_busy_in(busy), .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
    .data_out(data_out), .data_valid_out(data_valid_out), .write_launch_out(write_launch_out),
    .write_blocked_out(write_blocked_out), .standby_out(standby_out));
  // Core clock 4 ns; link clock 6 ns at an unrelated phase
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Capture one-cycle strobes mid-cycle, where they are settled
  always @(negedge clk_in) begin
    if (cmd_valid_out === 1'b1) begin
      cap_cmd = cmd_out;
      n_cmd++;
    end
    if (data_valid_out === 1'b1) begin
      cap_data = data_out;
      n_data++;
    end
    if (write_launch_out === 1'b1) n_launch++;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Target chosen by type and word selector
  function automatic eetw_target_t exp_tgt(input logic [7:0] dev, input logic [7:0] wrd);
    if (dev[7:4] == TYPE_ARRAY) return TGT_ARRAY;
    case (wrd[7:6])
      SEL_IDENTIFICATION_PAGE: return TGT_IDENTIFICATION_PAGE;
      SEL_LOCK: return TGT_LOCK;
      SEL_UNIQUE_ID: return TGT_UNIQUE_ID;
      default: return TGT_SOFT_PROTECT;
    endcase
  endfunction : exp_tgt
  // Expected acks of device, word and data bytes
  function automatic logic [2:0] exp_ack(input logic [7:0] dev, input logic [7:0] wrd, input logic [7:0] dat);
    logic m, d;
    m = (dev[7:4] == TYPE_ARRAY || dev[7:4] == TYPE_IDENT) && dev[3:2] == {csh, csl} && !busy && !por;
    case (exp_tgt(dev, wrd))
      TGT_ARRAY: d = !wp && !soft_protect_bit;
      TGT_IDENTIFICATION_PAGE: d = !wp && !soft_protect_bit && !lock;
      TGT_LOCK: d = !wp && dat[LOCK_DATA_BIT] && !lock;
      TGT_SOFT_PROTECT: d = !wp;
      default: d = 1'b0;
    endcase
    return {m && !dev[0] && d, m && !dev[0], m};
  endfunction : exp_ack
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Drive slow pins, then let the filters settle
  task automatic set_pins(input logic [6:0] v);
    @(posedge clk_in);
    {csh, csl, wp, soft_protect_bit, lock, busy, por} <= v;
    repeat (30) @(posedge clk_in);
    chk(write_blocked_out, wp | soft_protect_bit);
  endtask : set_pins
  // One command of n bytes, then Stop, then outcome checks
  task automatic run_cmd(input logic [7:0] dev, input logic [7:0] wrd, input logic [7:0] dat, input int n);
    logic [2:0] ea;
    logic a;
    int nc, nd, nl;
    ea = exp_ack(dev, wrd, dat);
    nc = n_cmd;
    nd = n_data;
    nl = n_launch;
    u_eetw_master_model.start();
    u_eetw_master_model.send_byte(dev, a);
    chk(a, ea[0]);
    if (a && n > 1) begin
      u_eetw_master_model.send_byte(wrd, a);
      chk(a, ea[1]);
    end
    if (a && n > 2) begin
      u_eetw_master_model.send_byte(dat, a);
      chk(a, ea[2]);
    end
    u_eetw_master_model.stop();
    repeat (40) @(posedge clk_in);
    chk(n_cmd - nc, ea[1] && n > 1);
    if (ea[1] && n > 1) begin
      chk(cap_cmd.target, exp_tgt(dev, wrd));
      chk(cap_cmd.word_address, wrd);
      if (dev[7:4] == TYPE_ARRAY) chk(cap_cmd.array_address, {dev[DEV_ADDR_MSB], wrd});
    end
    chk(n_data - nd, ea[2] && n > 2);
    if (ea[2] && n > 2) chk(cap_data, dat);
    chk(n_launch - nl, (&ea) && n > 2);
    chk(standby_out, !busy);
  endtask : run_cmd
  // Watchdog well beyond the expected run length
  initial begin
    repeat (95000) @(posedge clk_in);
    num_errors++;
    complete_run();
  end
  initial begin
    {csh, csl, wp, soft_protect_bit, lock, busy, por} = 7'h00;
    rst_in = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    set_pins(7'h00);
    chk(standby_out, 1'b1);
    run_cmd({TYPE_ARRAY, 4'h2}, 8'hFF, 8'h5A, 3);
    for (int s = 0; s < 4; s++) run_cmd({TYPE_IDENT, 4'h0}, {s[1:0], 6'h2A}, 8'h02, 3);
    run_cmd({TYPE_IDENT, 4'h0}, 8'h40, 8'hFD, 3);
    run_cmd(8'h50, 8'h00, 8'h00, 3);
    run_cmd(8'hA1, 8'h00, 8'h00, 1);
    u_eetw_master_model.recover();
    repeat (40) @(posedge clk_in);
    chk(standby_out, 1'b1);
    for (int i = 0; i < 20; i++) begin
      rnd = xs(rnd);
      set_pins({rnd[1:0], rnd[4:2] == 3'h0, rnd[7:5] == 3'h0, rnd[8], rnd[11:9] == 3'h0, rnd[14:12] == 3'h0});
      a_dev = {rnd[15] ? TYPE_ARRAY : TYPE_IDENT, rnd[16] ? rnd[1:0] : rnd[18:17], rnd[19], rnd[22:20] == 3'h0};
      rnd = xs(rnd);
      run_cmd(a_dev, rnd[7:0], rnd[15:8], 3);
    end
    complete_run();
  end
endmodule : eetw_slave_front_bench
`default_nettype wire
